// ===== psicfg_bank.sv
`timescale 1ns/10ps
// Function
// - Programming with lock set burns lock fuse, rereads array, rejects later writes
// - Once lock fuse is burnt, array parity check is enabled
// - Pulse-code pin carries modulation when enabled, otherwise driven low
// - Outside daisy chain, pulldown after sync only when pulldown enable set
// - Daisy chain: with pulldown enable set, pulldown if no address, or run command and address 001
// - Latency reference is sync pulse at zero, time slot at one
// - Response words are 10 bits at zero, 8 bits at one
// - After accepted sync, further syncs ignored per selected blanking method
// - Responses use even parity at zero, 3-bit CRC at one
// - Bit rate is 125 kBaud at zero, 190.5 kBaud at one
// - Two-bit mode field: normal, double rate, 16-bit, daisy chain
// - Filter field: 400 Hz three-pole, four-pole, two reserved codes
// - Slot fields count half-microsecond units, 0.5 to 511.5 us
// - Zero slot: default delay or free_running_enable mode; nonzero: slot from sync start
// - Second slot used only in double rate and 16-bit modes
// - Free_running_enable bit in neighbouring register enables free-running transmission
module psicfg_bank #(
   parameter int DEFAULT_SLOT_CYCLES = psicfg_pkg::DEFAULT_SLOT_DELAY_NS
                                       / psicfg_pkg::CLK_PERIOD_NS,
   parameter int MIN_BLANK_CYCLES    = psicfg_pkg::MIN_BLANK_NS / psicfg_pkg::CLK_PERIOD_NS
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        fuse_erase,
   input  wire logic        wr_en,
   input  wire logic [7:0]  wr_addr,
   input  wire logic [7:0]  wr_data,
   input  wire logic        rd_en,
   input  wire logic [7:0]  rd_addr,
   output logic      [7:0]  rd_data,
   output logic             rd_valid,
   output logic             wr_rejected,
   input  wire logic        prog_exec,
   output logic             prog_busy,
   input  wire logic        run_mode_cmd,
   input  wire logic [2:0]  chain_addr,
   input  wire logic        chain_addr_valid,
   input  wire logic        sync_pulse,
   input  wire logic        resp_done,
   input  wire logic        pcm_mod,
   output logic             pcm_out,
   output logic             pulldown_on,
   output logic             sync_accept,
   output logic             slot_start,
   output logic             second_slot_start,
   output logic             free_running,
   output logic             latency_slot_ref,
   output logic             word_length_8,
   output logic             crc_select,
   output logic             baud_tick,
   output logic      [1:0]  transmission_mode,
   output logic      [1:0]  lowpass_select,
   output logic             lowpass_reserved,
   output logic             array_check_on,
   output logic             array_error
);
   localparam int N = psicfg_pkg::NUM_REGS;
   localparam int W = psicfg_pkg::CNT_W;
   localparam logic [W-1:0] DEF_SLOT  = W'(DEFAULT_SLOT_CYCLES);
   localparam logic [W-1:0] MIN_BLANK = W'(MIN_BLANK_CYCLES);
   localparam logic [W-1:0] ONE       = W'(1);

   psicfg_cfg_if cfg ();

   logic [7:0]                 fuse_reg  [N];
   logic [7:0]                 stage_reg [N];
   logic [7:0]                 cfg_reg   [N];
   logic                       check_fuse_reg;
   logic                       check_fuse_next;
   psicfg_pkg::psicfg_state_t  state_reg;
   logic [7:0]                 burnt     [N];
   logic [N-1:0]               wr_hit;
   logic [N-1:0]               rd_hit;
   logic                       locked;
   logic [W-1:0]               slot_a_cyc;
   logic [W-1:0]               slot_b_cyc;
   logic [W-1:0]               since_sync_reg;
   logic                       timing_reg;
   logic                       blank_reg;
   logic                       resp_seen_reg;
   logic [1:0]                 resp_cnt_reg;
   logic                       pd_allowed;
   logic                       run_seen_reg;
   logic [W-1:0]               baud_cnt_reg;
   logic [W-1:0]               baud_limit;
   logic [7:0]                 rd_mux;
   logic                       blank_done;

   psicfg_field_decode u_decode (
      .cfg (cfg.dec)
   );

   // One entry per register: address match, burn result, active copy
   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_entry
         localparam logic [7:0] ADDR = psicfg_pkg::ADDR_LINK + 8'(gi);
         assign wr_hit[gi]       = (wr_addr == ADDR);
         assign rd_hit[gi]       = (rd_addr == ADDR);
         assign burnt[gi]        = fuse_reg[gi] | stage_reg[gi];
         assign cfg.cfg_byte[gi] = cfg_reg[gi];

         // Fuses ignore rst: they model non-volatile cells, cleared only by fuse_erase
         always_ff @(posedge clk) begin
            if (fuse_erase) begin
               fuse_reg[gi] <= psicfg_pkg::RESET_VALUE;
            end else if (state_reg == psicfg_pkg::ST_BURN) begin
               fuse_reg[gi] <= burnt[gi];
            end
         end

         always_ff @(posedge clk) begin
            if (rst) begin
               stage_reg[gi] <= psicfg_pkg::RESET_VALUE;
            end else if (wr_en && wr_hit[gi] && !locked && !prog_busy) begin
               stage_reg[gi] <= wr_data;
            end
         end

         always_ff @(posedge clk) begin
            if (rst) begin
               cfg_reg[gi] <= psicfg_pkg::RESET_VALUE;
            end else if (state_reg == psicfg_pkg::ST_READ) begin
               cfg_reg[gi] <= fuse_reg[gi];
            end
         end
      end
   endgenerate

   assign locked = cfg.lock_bit;

   always_comb begin
      check_fuse_next = 1'b0;
      for (int i = 0; i < N; i++) begin
         check_fuse_next = check_fuse_next ^ (^burnt[i]);
      end
   end

   // Check value is burnt together with the lock so it covers the final contents
   always_ff @(posedge clk) begin
      if (fuse_erase) begin
         check_fuse_reg <= 1'b0;
      end else if (state_reg == psicfg_pkg::ST_BURN &&
                   burnt[psicfg_pkg::IDX_LINK][psicfg_pkg::BIT_LOCK]) begin
         check_fuse_reg <= check_fuse_next;
      end
   end

   // Readout follows every reset and every burn
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= psicfg_pkg::ST_READ;
      end else begin
         case (state_reg)
            psicfg_pkg::ST_IDLE: begin
               if (prog_exec && !locked) begin
                  state_reg <= psicfg_pkg::ST_BURN;
               end
            end
            psicfg_pkg::ST_BURN: begin
               state_reg <= psicfg_pkg::ST_READ;
            end
            psicfg_pkg::ST_READ: begin
               state_reg <= psicfg_pkg::ST_IDLE;
            end
            default: begin
               state_reg <= psicfg_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prog_busy <= 1'b1;
      end else begin
         prog_busy <= (state_reg == psicfg_pkg::ST_IDLE) ? (prog_exec && !locked)
                                                          : (state_reg == psicfg_pkg::ST_BURN);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         array_check_on <= 1'b0;
         array_error    <= 1'b0;
      end else if (state_reg == psicfg_pkg::ST_READ) begin
         array_check_on <= fuse_reg[psicfg_pkg::IDX_LINK][psicfg_pkg::BIT_LOCK];
         // Sticky until reset: a mismatch must not heal on a later readout
         if (fuse_reg[psicfg_pkg::IDX_LINK][psicfg_pkg::BIT_LOCK] &&
             (check_fuse_next != check_fuse_reg)) begin
            array_error <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_rejected <= 1'b0;
      end else begin
         wr_rejected <= wr_en && (|wr_hit) && (locked || prog_busy);
      end
   end

   always_comb begin
      rd_mux = 8'h00;
      for (int i = 0; i < N; i++) begin
         if (rd_hit[i]) begin
            rd_mux = cfg_reg[i];
         end
      end
      if (rd_hit[psicfg_pkg::IDX_FREE_RUNNING_ENABLE]) begin
         rd_mux = cfg_reg[psicfg_pkg::IDX_FREE_RUNNING_ENABLE] & (8'h01 << psicfg_pkg::BIT_FREE_RUNNING_ENABLE);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data  <= 8'h00;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd_en;
         if (rd_en) begin
            rd_data <= rd_mux;
         end
      end
   end

   // Registered copies of the decoded fields
   always_ff @(posedge clk) begin
      if (rst) begin
         pcm_out           <= 1'b0;
         free_running      <= 1'b0;
         latency_slot_ref  <= 1'b0;
         word_length_8     <= 1'b0;
         crc_select        <= 1'b0;
         transmission_mode <= 2'h0;
         lowpass_select    <= 2'h0;
         lowpass_reserved  <= 1'b0;
      end else begin
         pcm_out           <= cfg.pcm_en && pcm_mod;
         free_running      <= cfg.free_running_enable_mode;
         latency_slot_ref  <= cfg.latency_slot;
         word_length_8     <= cfg.word8;
         crc_select        <= cfg.use_crc;
         transmission_mode <= cfg.mode;
         lowpass_select    <= cfg.lpf_sel;
         lowpass_reserved  <= cfg.lpf_reserved;
      end
   end

   // Half-microsecond units; 62.5 cycles each, so the start rounds down
   assign slot_a_cyc = cfg.slot_a_default ? DEF_SLOT
                     : W'((32'(cfg.slot_a) * psicfg_pkg::SLOT_UNIT_PS)
                          / psicfg_pkg::CLK_PERIOD_PS);
   assign slot_b_cyc = W'((32'(cfg.slot_b) * psicfg_pkg::SLOT_UNIT_PS)
                          / psicfg_pkg::CLK_PERIOD_PS);

   always_ff @(posedge clk) begin
      if (rst) begin
         sync_accept <= 1'b0;
      end else begin
         sync_accept <= sync_pulse && !blank_reg && (state_reg == psicfg_pkg::ST_IDLE);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         since_sync_reg <= '0;
         timing_reg     <= 1'b0;
      end else if (sync_accept) begin
         since_sync_reg <= ONE;
         timing_reg     <= 1'b1;
      end else if (timing_reg && since_sync_reg != '1) begin
         since_sync_reg <= since_sync_reg + ONE;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         slot_start        <= 1'b0;
         second_slot_start <= 1'b0;
      end else begin
         slot_start        <= timing_reg && !cfg.free_running_enable_mode &&
                              (since_sync_reg == slot_a_cyc);
         second_slot_start <= timing_reg && cfg.use_slot_b && !cfg.free_running_enable_mode &&
                              (cfg.slot_b != '0) && (since_sync_reg == slot_b_cyc);
      end
   end

   assign blank_done = cfg.blank_by_slot
                     ? (resp_done && resp_cnt_reg == (cfg.use_slot_b ? 2'h1 : 2'h0))
                     : ((resp_seen_reg || resp_done) && since_sync_reg >= MIN_BLANK);

   always_ff @(posedge clk) begin
      if (rst) begin
         blank_reg     <= 1'b0;
         resp_seen_reg <= 1'b0;
         resp_cnt_reg  <= 2'h0;
      end else if (sync_accept) begin
         blank_reg     <= 1'b1;
         resp_seen_reg <= 1'b0;
         resp_cnt_reg  <= 2'h0;
      end else if (blank_reg) begin
         if (blank_done) begin
            blank_reg <= 1'b0;
         end
         if (resp_done) begin
            resp_seen_reg <= 1'b1;
            resp_cnt_reg  <= resp_cnt_reg + 2'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         run_seen_reg <= 1'b0;
      end else if (run_mode_cmd) begin
         run_seen_reg <= 1'b1;
      end
   end

   always_comb begin
      if (cfg.mode != psicfg_pkg::MODE_DAISY) begin
         pd_allowed = cfg.sync_pulldown_enable;
      end else begin
         pd_allowed = cfg.sync_pulldown_enable && (!chain_addr_valid ||
                      (run_seen_reg && chain_addr == psicfg_pkg::DAISY_FIRST));
      end
   end

   // Pulldown spans from an accepted sync to the end of the first response
   always_ff @(posedge clk) begin
      if (rst) begin
         pulldown_on <= 1'b0;
      end else if (sync_accept) begin
         pulldown_on <= pd_allowed;
      end else if (resp_done || !pd_allowed) begin
         pulldown_on <= 1'b0;
      end
   end

   assign baud_limit = cfg.baud_high ? W'(psicfg_pkg::BAUD_HIGH_CYC)
                                     : W'(psicfg_pkg::BAUD_LOW_CYC);

   always_ff @(posedge clk) begin
      if (rst) begin
         baud_cnt_reg <= '0;
         baud_tick    <= 1'b0;
      end else if (baud_cnt_reg >= baud_limit - ONE) begin
         baud_cnt_reg <= '0;
         baud_tick    <= 1'b1;
      end else begin
         baud_cnt_reg <= baud_cnt_reg + ONE;
         baud_tick    <= 1'b0;
      end
   end
endmodule

// ===== psicfg_pkg.sv
package psicfg_pkg;
   localparam int          NUM_REGS      = 5;
   localparam logic [7:0]  ADDR_LINK     = 8'h05;
   localparam logic [7:0]  ADDR_MODE     = 8'h06;
   localparam logic [7:0]  ADDR_SLOTA    = 8'h07;
   localparam logic [7:0]  ADDR_SLOTB    = 8'h08;
   localparam logic [7:0]  ADDR_FREE_RUNNING_ENABLE    = 8'h09;
   localparam logic [7:0]  RESET_VALUE   = 8'h00;
   localparam int          IDX_LINK      = 0;
   localparam int          IDX_MODE      = 1;
   localparam int          IDX_SLOTA     = 2;
   localparam int          IDX_SLOTB     = 3;
   localparam int          IDX_FREE_RUNNING_ENABLE     = 4;
   localparam int          BIT_LOCK      = 7;
   localparam int          BIT_PCM       = 6;
   localparam int          BIT_SYNC_PULLDOWN_ENABLE   = 5;
   localparam int          BIT_LATENCY   = 4;
   localparam int          BIT_WORDLEN   = 3;
   localparam int          BIT_BLANK     = 2;
   localparam int          BIT_CRC       = 1;
   localparam int          BIT_BAUD      = 0;
   localparam int          MODE_MSB      = 7;
   localparam int          MODE_LSB      = 6;
   localparam int          LPF_MSB       = 5;
   localparam int          LPF_LSB       = 4;
   localparam int          SLOTB_HI_MSB  = 3;
   localparam int          SLOTB_HI_LSB  = 2;
   localparam int          SLOTA_HI_MSB  = 1;
   localparam int          SLOTA_HI_LSB  = 0;
   localparam int          BIT_FREE_RUNNING_ENABLE     = 6;
   localparam int          SLOT_W        = 10;
   localparam int          CNT_W         = 18;
   localparam logic [2:0]  DAISY_FIRST   = 3'h1;
   localparam logic [1:0]  LPF_3POLE     = 2'h0;
   localparam logic [1:0]  LPF_4POLE     = 2'h1;
   localparam int          CLK_HZ        = 125000000;
   localparam int          CLK_PERIOD_PS = 8000;
   localparam int          SLOT_UNIT_PS  = 500000;
   localparam int          BAUD_LOW_HZ   = 125000;
   localparam int          BAUD_HIGH_DHZ = 1905000;
   localparam int          BAUD_LOW_CYC  = CLK_HZ / BAUD_LOW_HZ;
   localparam int          BAUD_HIGH_CYC = (CLK_HZ / BAUD_HIGH_DHZ) * 10
                                           + ((CLK_HZ % BAUD_HIGH_DHZ) * 10) / BAUD_HIGH_DHZ;
   localparam int          DEFAULT_SLOT_DELAY_NS = 50000;
   localparam int          MIN_BLANK_NS  = 250000;
   localparam int          CLK_PERIOD_NS = 8;
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'h0,
      MODE_DOUBLE = 2'h1,
      MODE_RES16  = 2'h2,
      MODE_DAISY  = 2'h3
   } psicfg_mode_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_BURN = 2'h1,
      ST_READ = 2'h3
   } psicfg_state_t;
endpackage

// ===== psicfg_cfg_if.sv
`timescale 1ns/10ps
interface psicfg_cfg_if;
   logic [7:0]                      cfg_byte [psicfg_pkg::NUM_REGS];
   logic                            lock_bit;
   logic                            pcm_en;
   logic                            sync_pulldown_enable;
   logic                            latency_slot;
   logic                            word8;
   logic                            blank_by_slot;
   logic                            use_crc;
   logic                            baud_high;
   psicfg_pkg::psicfg_mode_t        mode;
   logic [1:0]                      lpf_sel;
   logic                            lpf_reserved;
   logic                            free_running_enable_mode;
   logic                            slot_a_default;
   logic                            use_slot_b;
   logic [psicfg_pkg::SLOT_W-1:0]   slot_a;
   logic [psicfg_pkg::SLOT_W-1:0]   slot_b;
   modport bank (output cfg_byte, input lock_bit, pcm_en, sync_pulldown_enable, latency_slot, word8,
                 blank_by_slot, use_crc, baud_high, mode, lpf_sel, lpf_reserved,
                 free_running_enable_mode, slot_a_default, use_slot_b, slot_a, slot_b);
   modport dec  (input cfg_byte, output lock_bit, pcm_en, sync_pulldown_enable, latency_slot, word8,
                 blank_by_slot, use_crc, baud_high, mode, lpf_sel, lpf_reserved,
                 free_running_enable_mode, slot_a_default, use_slot_b, slot_a, slot_b);
endinterface

// ===== psicfg_field_decode.sv
`timescale 1ns/10ps
module psicfg_field_decode (
   psicfg_cfg_if.dec cfg
);
   logic [7:0] link_b;
   logic [7:0] mode_b;
   always_comb begin
      link_b             = cfg.cfg_byte[psicfg_pkg::IDX_LINK];
      mode_b             = cfg.cfg_byte[psicfg_pkg::IDX_MODE];
      cfg.lock_bit       = link_b[psicfg_pkg::BIT_LOCK];
      cfg.pcm_en         = link_b[psicfg_pkg::BIT_PCM];
      cfg.sync_pulldown_enable        = link_b[psicfg_pkg::BIT_SYNC_PULLDOWN_ENABLE];
      cfg.latency_slot   = link_b[psicfg_pkg::BIT_LATENCY];
      cfg.word8          = link_b[psicfg_pkg::BIT_WORDLEN];
      cfg.blank_by_slot  = link_b[psicfg_pkg::BIT_BLANK];
      cfg.use_crc        = link_b[psicfg_pkg::BIT_CRC];
      cfg.baud_high      = link_b[psicfg_pkg::BIT_BAUD];
      cfg.mode           = psicfg_pkg::psicfg_mode_t'(
                              mode_b[psicfg_pkg::MODE_MSB:psicfg_pkg::MODE_LSB]);
      cfg.lpf_sel        = mode_b[psicfg_pkg::LPF_MSB:psicfg_pkg::LPF_LSB];
      cfg.lpf_reserved   = (cfg.lpf_sel != psicfg_pkg::LPF_3POLE) &&
                           (cfg.lpf_sel != psicfg_pkg::LPF_4POLE);
      cfg.slot_a         = {mode_b[psicfg_pkg::SLOTA_HI_MSB:psicfg_pkg::SLOTA_HI_LSB],
                            cfg.cfg_byte[psicfg_pkg::IDX_SLOTA]};
      cfg.slot_b         = {mode_b[psicfg_pkg::SLOTB_HI_MSB:psicfg_pkg::SLOTB_HI_LSB],
                            cfg.cfg_byte[psicfg_pkg::IDX_SLOTB]};
      // Zero slot picks default delay or free running, set by the free_running_enable bit
      cfg.free_running_enable_mode     = (cfg.slot_a == '0) &&
                           cfg.cfg_byte[psicfg_pkg::IDX_FREE_RUNNING_ENABLE][psicfg_pkg::BIT_FREE_RUNNING_ENABLE];
      cfg.slot_a_default = (cfg.slot_a == '0) && !cfg.free_running_enable_mode;
      cfg.use_slot_b     = (cfg.mode == psicfg_pkg::MODE_DOUBLE) ||
                           (cfg.mode == psicfg_pkg::MODE_RES16);
   end
endmodule

// ===== psicfg_bank_asserts.sv
`timescale 1ns/10ps
module psicfg_bank_asserts (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       rd_en,
   input wire logic       rd_valid,
   input wire logic       pcm_mod,
   input wire logic       pcm_out,
   input wire logic       prog_exec,
   input wire logic       prog_busy,
   input wire logic       array_check_on,
   input wire logic       wr_en,
   input wire logic [7:0] wr_addr,
   input wire logic       wr_rejected,
   input wire logic       sync_pulse,
   input wire logic       sync_accept,
   input wire logic       second_slot_start,
   input wire logic [1:0] transmission_mode,
   input wire logic       baud_tick,
   input wire logic       array_error
);
   logic [9:0] gap_reg;
   logic [1:0] ticks_reg;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   always_ff @(posedge clk) begin
      gap_reg <= baud_tick ? 10'h000 : gap_reg + 10'h001;
   end
   // Period judged only after two ticks: a config change may cut one period short
   always_ff @(posedge clk) begin
      if (rst || prog_busy) begin
         ticks_reg <= 2'h0;
      end else if (baud_tick && ticks_reg != 2'h2) begin
         ticks_reg <= ticks_reg + 2'h1;
      end
   end
   rd_answer_a: assert property (rd_en |=> rd_valid)
      else $error("read not answered");
   pcm_gate_a: assert property (pcm_out |-> $past(pcm_mod))
      else $error("pcm output without modulation");
   prog_seq_a: assert property (prog_exec && !prog_busy && !array_check_on
      |=> prog_busy [*2] ##1 !prog_busy) else $error("programming sequence wrong");
   wr_refuse_a: assert property (wr_en && (array_check_on || prog_busy)
      && wr_addr >= 8'h05 && wr_addr <= 8'h09 |=> wr_rejected) else $error("write not refused");
   sync_cause_a: assert property (sync_accept |-> $past(sync_pulse))
      else $error("sync accepted without pulse");
   second_mode_a: assert property (second_slot_start
      |-> transmission_mode inside {2'h1, 2'h2}) else $error("second slot in wrong mode");
   baud_period_a: assert property (baud_tick && ticks_reg == 2'h2
      |-> gap_reg == 10'h3e7 || gap_reg == 10'h28f) else $error("baud period wrong");
   error_sticky_a: assert property (array_error |=> array_error)
      else $error("array error not held");
endmodule
bind psicfg_bank psicfg_bank_asserts u_chk (.clk(clk), .rst(rst), .rd_en(rd_en),
   .rd_valid(rd_valid), .pcm_mod(pcm_mod), .pcm_out(pcm_out), .prog_exec(prog_exec),
   .prog_busy(prog_busy), .array_check_on(array_check_on), .wr_en(wr_en), .wr_addr(wr_addr),
   .wr_rejected(wr_rejected), .sync_pulse(sync_pulse), .sync_accept(sync_accept),
   .second_slot_start(second_slot_start), .transmission_mode(transmission_mode),
   .baud_tick(baud_tick), .array_error(array_error));

// ===== psicfg_rx_model.sv
`timescale 1ns/10ps
module psicfg_rx_model #(
   parameter int RESP_CYCLES = 30
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic slot_start,
   input  wire logic second_slot_start,
   output logic      resp_done
);
   int left_reg;
   // Each slot start opens one response frame of fixed length
   always_ff @(posedge clk) begin
      resp_done <= !rst && left_reg == 1;
      if (rst) begin
         left_reg <= 0;
      end else if (slot_start || second_slot_start) begin
         left_reg <= RESP_CYCLES;
      end else if (left_reg > 0) begin
         left_reg <= left_reg - 1;
      end
   end
endmodule

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
   logic       clk, rst, fuse_erase, wr_en, rd_en, prog_exec, sync_pulse, pcm_mod;
   logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
   logic       rd_valid, wr_rejected, prog_busy, pcm_out, pulldown_on, sync_accept;
   logic       slot_start, second_slot_start, free_running, latency_slot_ref, word_length_8;
   logic       crc_select, baud_tick, lowpass_reserved, array_check_on, array_error, resp_done;
   logic [1:0] transmission_mode, lowpass_select;
   logic       run_cmd, chain_ok;
   logic [2:0] chain_a;
   logic [7:0] exp_q[$];
   logic [7:0] acc [5];
   logic [31:0] seed, r32;
   int         mismatches, checks_done, cyc, n_acc, n_rej, t_acc, t_slot, t_sec;
   psicfg_bank #(.DEFAULT_SLOT_CYCLES(20), .MIN_BLANK_CYCLES(40)) dut (.clk(clk), .rst(rst),
      .fuse_erase(fuse_erase), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
      .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
      .wr_rejected(wr_rejected), .prog_exec(prog_exec), .prog_busy(prog_busy),
      .run_mode_cmd(run_cmd), .chain_addr(chain_a), .chain_addr_valid(chain_ok),
      .sync_pulse(sync_pulse), .resp_done(resp_done), .pcm_mod(pcm_mod), .pcm_out(pcm_out),
      .pulldown_on(pulldown_on), .sync_accept(sync_accept), .slot_start(slot_start),
      .second_slot_start(second_slot_start), .free_running(free_running),
      .latency_slot_ref(latency_slot_ref), .word_length_8(word_length_8),
      .crc_select(crc_select), .baud_tick(baud_tick), .transmission_mode(transmission_mode),
      .lowpass_select(lowpass_select), .lowpass_reserved(lowpass_reserved),
      .array_check_on(array_check_on), .array_error(array_error));
   psicfg_rx_model u_rx (.clk(clk), .rst(rst), .slot_start(slot_start),
      .second_slot_start(second_slot_start), .resp_done(resp_done));
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check_val(input string what, input logic [7:0] e, input logic [7:0] s);
      checks_done++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic pulse(input int sel, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_en <= sel == 0;
      rd_en <= sel == 1;
      prog_exec <= sel == 2;
      sync_pulse <= sel == 3;
      wr_addr <= a;
      rd_addr <= a;
      wr_data <= d;
      @(posedge clk);
      {wr_en, rd_en, prog_exec, sync_pulse} <= 4'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      pulse(1, a, 8'h00);
   endtask
   task automatic prog();
      pulse(2, 8'h00, 8'h00);
      tick(4);
   endtask
   task automatic reset_erase();
      @(posedge clk);
      {rst, fuse_erase} <= 2'h3;
      tick(4);
      {rst, fuse_erase} <= 2'h0;
      tick(3);
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (rd_valid === 1'b1) check_val("rd_data", exp_q.pop_front(), rd_data);
      if (wr_rejected === 1'b1) n_rej++;
      if (sync_accept === 1'b1) begin
         n_acc++;
         t_acc = cyc;
      end
      if (slot_start === 1'b1) t_slot = cyc;
      if (second_slot_start === 1'b1) t_sec = cyc;
   end
   initial begin
      #(8 * 20000);
      mismatches++;
      final_report();
   end
   initial begin
      {wr_en, rd_en, prog_exec, sync_pulse, rst, fuse_erase, pcm_mod} = 7'h7;
      {wr_addr, wr_data, rd_addr} = 24'h0000_00;
      seed = 32'h04e5_9677;
      {run_cmd, chain_ok, chain_a} = 5'h09;
      acc = '{default: 8'h00};
      reset_erase();
      for (int a = 5; a <= 10; a++) rd(a[7:0], 8'h00);
      for (int i = 0; i < 2; i++) begin
         for (int r = 0; r < 5; r++) begin
            r32 = $random(seed);
            r32[7] = r32[7] & (r != 0);
            pulse(0, psicfg_pkg::ADDR_LINK + r[7:0], r32[7:0]);
            if (r == 0) rd(psicfg_pkg::ADDR_LINK, acc[0]);
            acc[r] = acc[r] | (r == 4 ? r32[7:0] & 8'h40 : r32[7:0]);
         end
         pcm_mod <= r32[8];
         prog();
         check_val("busy", 8'h00, {7'h00, prog_busy});
         for (int r = 0; r < 5; r++) rd(psicfg_pkg::ADDR_LINK + r[7:0], acc[r]);
         check_val("levels", {acc[0][4], acc[0][3], acc[0][1],
            acc[4][6] && {acc[1][1:0], acc[2]} == 10'h000, acc[1][7:4]},
            {latency_slot_ref, word_length_8, crc_select, free_running, transmission_mode,
            lowpass_select});
         check_val("pcm_lpf", {6'h00, acc[0][6] & r32[8], acc[1][5]},
            {6'h00, pcm_out, lowpass_reserved});
      end
      reset_erase();
      // Parity with 10-bit words, slot B well clear of the default slot A
      pulse(0, 8'h05, 8'h20);
      pulse(0, 8'h06, 8'h40);
      pulse(0, 8'h08, 8'h0a);
      prog();
      n_acc = 0;
      pulse(3, 8'h00, 8'h00);
      tick(12);
      pulse(3, 8'h00, 8'h00);
      check_val("pulldown", 8'h01, {7'h00, pulldown_on});
      tick(800);
      check_val("accepts", 8'h01, n_acc[7:0]);
      check_val("slot_a", 8'h01, {7'h00, (t_slot - t_acc) inside {[19:22]}});
      check_val("slot_b", 8'h01, {7'h00, (t_sec - t_acc) inside {[624:627]}});
      pulse(0, 8'h06, 8'hc0);
      prog();
      pulse(3, 8'h00, 8'h00);
      tick(2);
      check_val("pd_wait", 8'h00, {7'h00, pulldown_on});
      run_cmd <= 1'b1;
      tick(100);
      pulse(3, 8'h00, 8'h00);
      tick(2);
      check_val("pd_run", 8'h01, {7'h00, pulldown_on});
      pulse(0, 8'h05, 8'ha0);
      prog();
      check_val("lock", 8'h02, {6'h00, array_check_on, array_error});
      pulse(0, 8'h06, 8'hff);
      prog();
      rd(8'h06, 8'hc0);
      check_val("rejects", 8'h01, n_rej[7:0]);
      tick(4);
      final_report();
   end
endmodule
